// [nvc_pkg.sv]
package nvc_pkg;
   localparam int ADDR_W = 13;
   localparam int DATA_W = 8;
   // software sequence addresses
   localparam logic [12:0] SEQ_A0 = 13'h0000;
   localparam logic [12:0] SEQ_A1 = 13'h1555;
   localparam logic [12:0] SEQ_A2 = 13'h0AAA;
   localparam logic [12:0] SEQ_A3 = 13'h1FFF;
   localparam logic [12:0] SEQ_A4 = 13'h10F0;
   localparam logic [12:0] SEQ_STORE = 13'h0F0F;
   localparam logic [12:0] SEQ_RECALL = 13'h0F0E;
   // timing in ns, us and ms as the names say, clock 50 ns
   localparam int CLK_NS = 50;
   localparam int T_CYCLE_NS = 150;
   localparam int T_ASSERT_NS = 250;
   localparam int T_RECOVER_NS = 300;
   localparam int T_RECALL_US = 25;
   localparam int T_STORE_MS = 12;
   localparam int CYC_PHASE = (T_CYCLE_NS + CLK_NS - 1) / CLK_NS;
   localparam int CYC_ASSERT = (T_ASSERT_NS + CLK_NS - 1) / CLK_NS;
   localparam int CYC_RECOVER = (T_RECOVER_NS + CLK_NS - 1) / CLK_NS;
   localparam int CYC_RECALL = (T_RECALL_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int CYC_STORE = (T_STORE_MS * 1000000 + CLK_NS - 1) / CLK_NS;
   localparam int CNT_W = 20;
   // host commands
   typedef enum logic [2:0] {
      NVC_OP_READ = 3'h0,
      NVC_OP_WRITE = 3'h1,
      NVC_OP_SW_STORE = 3'h2,
      NVC_OP_SW_RECALL = 3'h3,
      NVC_OP_HW_STORE = 3'h4
   } nvc_op_e;
   typedef struct packed {
      nvc_op_e op;
      logic [12:0] addr;
      logic [7:0] data;
   } nvc_req_s;
   // pins toward the memory
   typedef struct packed {
      logic ce_n;
      logic we_n;
      logic oe_n;
      logic [12:0] addr;
      logic [7:0] dq_out;
      logic dq_oe;
      logic store_busy_n_out;
      logic store_busy_n_oe;
   } nvc_pins_s;
endpackage : nvc_pkg

// [nvc_timer.sv]
module nvc_timer
   import nvc_pkg::*;
#(
   parameter int W = CNT_W
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // load and status
   input wire logic load_i,
   input wire logic [W-1:0] count_i,
   output logic done_o
);
   logic [W-1:0] cnt_q;
   // down counter, done while zero
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_q <= '0;
      end else if (load_i) begin
         cnt_q <= count_i;
      end else if (cnt_q != '0) begin
         cnt_q <= cnt_q - 1'b1;
      end
   end
   // done looks at the count only: the parent derives load from done, so gating by load would loop
   assign done_o = (cnt_q == '0);
endmodule // nvc_timer

// [nvc_host.sv]
// Contract
// [R1] read with select and output enable low
// [R2] write with select and strobe low
// [R3] host keeps strobe high through reads
// [R4] held selection gives data per address
// [R5] strobe low at select: data off
// [R6] six reads ending 0F0F start store
// [R7] six reads ending 0F0E start recall
// [R8] host keeps strobe high during sequence
// [R9] sequence start ignores output enable
// [R10] busy-line store only after writes
// [R11] busy low: inhibit until released
// [R12] deselect waits for transfer end
// [R13] triggered transfer ignores all pins
// [R14] wrong address or write restarts sequence
// [R15] deselected: data released, inputs ignored
module nvc_host
   import nvc_pkg::*;
#(
   parameter int STORE_CYC = CYC_STORE,
   parameter int RECALL_CYC = CYC_RECALL
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // request side
   input wire nvc_req_s req_i,
   input wire logic req_valid_i,
   output logic req_ready_o,
   output logic [7:0] rdata_o,
   output logic rdata_valid_o,
   output logic done_o,
   // memory pins
   output nvc_pins_s pins_o,
   input wire logic [7:0] dq_i,
   input wire logic store_busy_n_i
);
   typedef enum logic [5:0] {
      ST_IDLE = 6'b000001,
      ST_SETUP = 6'b000010,
      ST_STROBE = 6'b000100,
      ST_HOLD = 6'b001000,
      ST_NVWAIT = 6'b010000,
      ST_BUSY = 6'b100000
   } nvc_st_e;

   nvc_st_e st_q;
   nvc_req_s cur_q;
   logic [2:0] step_q;
   logic [1:0] sb_sync_q;
   logic [7:0] dq_sync1_q, dq_sync2_q;
   logic tmr_load;
   logic [CNT_W-1:0] tmr_count;
   logic tmr_done;
   logic seq_op;
   logic strobe_act;
   logic [7:0] rd_hold_q;

   // address of sequence step n, last step chosen by command
   function automatic logic [12:0] seq_addr(input logic [2:0] n, input nvc_op_e op);
      case (n)
         3'd0: seq_addr = SEQ_A0;
         3'd1: seq_addr = SEQ_A1;
         3'd2: seq_addr = SEQ_A2;
         3'd3: seq_addr = SEQ_A3;
         3'd4: seq_addr = SEQ_A4;
         default: seq_addr = (op == NVC_OP_SW_STORE) ? SEQ_STORE : SEQ_RECALL; // [R6] [R7]
      endcase
   endfunction

   assign seq_op = (cur_q.op == NVC_OP_SW_STORE) || (cur_q.op == NVC_OP_SW_RECALL);
   // strobe phase minus its last cycle, so the registered pins release as hold begins; busy-line store keeps the whole phase
   assign strobe_act = (st_q == ST_STROBE) && !(tmr_done && cur_q.op != NVC_OP_HW_STORE);

   // pin inputs pass two flops before use
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         sb_sync_q <= 2'b11;
         dq_sync1_q <= 8'h00;
         dq_sync2_q <= 8'h00;
      end else begin
         sb_sync_q <= {sb_sync_q[0], store_busy_n_i};
         dq_sync1_q <= dq_i;
         dq_sync2_q <= dq_sync1_q;
      end
   end

   // phase and transfer timer
   always_comb begin
      tmr_load = 1'b0;
      tmr_count = '0;
      case (st_q)
         ST_IDLE: begin
            tmr_load = req_valid_i;
            tmr_count = (req_valid_i && req_i.op == NVC_OP_HW_STORE) ? CNT_W'(CYC_ASSERT) : CNT_W'(CYC_PHASE);
         end
         ST_SETUP, ST_HOLD: begin
            tmr_load = tmr_done;
            tmr_count = CNT_W'(CYC_PHASE);
         end
         ST_STROBE: begin
            tmr_load = tmr_done;
            tmr_count = CNT_W'(CYC_PHASE);
            if (tmr_done && seq_op && step_q == 3'd5) begin
               tmr_count = (cur_q.op == NVC_OP_SW_STORE) ? CNT_W'(STORE_CYC) : CNT_W'(RECALL_CYC); // [R12]
            end else if (tmr_done && cur_q.op == NVC_OP_HW_STORE) begin
               tmr_count = CNT_W'(CYC_RECOVER);
            end
         end
         default: begin
            tmr_load = 1'b0;
            tmr_count = '0;
         end
      endcase
   end

   nvc_timer #(.W(CNT_W)) u_timer (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .load_i(tmr_load),
      .count_i(tmr_count),
      .done_o(tmr_done)
   );

   // sequencer: setup with select high, strobe, hold with select high
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_q <= ST_IDLE;
         cur_q <= '0;
         step_q <= 3'd0;
      end else begin
         case (st_q)
            ST_IDLE: begin
               if (req_valid_i) begin
                  cur_q <= req_i;
                  step_q <= 3'd0;
                  st_q <= (req_i.op == NVC_OP_HW_STORE) ? ST_STROBE : ST_SETUP;
               end
            end
            ST_SETUP: if (tmr_done) begin
               st_q <= ST_STROBE;
            end
            ST_STROBE: if (tmr_done) begin
               if (cur_q.op == NVC_OP_HW_STORE) begin
                  st_q <= ST_BUSY;
               end else if (seq_op && step_q == 3'd5) begin
                  st_q <= ST_NVWAIT; // [R13]
               end else begin
                  st_q <= ST_HOLD;
               end
            end
            ST_HOLD: if (tmr_done) begin
               if (seq_op && step_q != 3'd5) begin
                  step_q <= step_q + 3'd1;
                  st_q <= ST_STROBE; // back to back reads, no extra setup
               end else begin
                  st_q <= ST_IDLE;
               end
            end
            ST_NVWAIT: if (tmr_done) begin
               st_q <= ST_IDLE;
            end
            ST_BUSY: if (tmr_done && sb_sync_q[1]) begin
               st_q <= ST_IDLE; // [R11]
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   // pin drive, all registered
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pins_o <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: 13'h0000, dq_out: 8'h00,
                     dq_oe: 1'b0, store_busy_n_out: 1'b0, store_busy_n_oe: 1'b0};
      end else begin
         // one assignment per pin: a default-then-override pair would glitch a held-low select
         pins_o.ce_n <= !(strobe_act && cur_q.op != NVC_OP_HW_STORE); // [R15] [R9]
         pins_o.we_n <= !(strobe_act && cur_q.op == NVC_OP_WRITE); // [R3] [R8]
         pins_o.oe_n <= !(strobe_act && cur_q.op == NVC_OP_READ); // [R1] [R4]
         pins_o.dq_oe <= strobe_act && (cur_q.op == NVC_OP_WRITE); // [R2] [R5]
         pins_o.store_busy_n_out <= 1'b0;
         pins_o.store_busy_n_oe <= strobe_act && (cur_q.op == NVC_OP_HW_STORE); // [R10]
         // next sequence address goes out during hold, so it is stable before select falls
         pins_o.addr <= seq_op ? seq_addr((st_q == ST_HOLD) ? step_q + 3'd1 : step_q, cur_q.op)
                               : cur_q.addr; // [R14]
         pins_o.dq_out <= cur_q.data;
      end
   end

   // answers toward the requester
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         req_ready_o <= 1'b0;
         rdata_o <= 8'h00;
         rd_hold_q <= 8'h00;
         rdata_valid_o <= 1'b0;
         done_o <= 1'b0;
      end else begin
         req_ready_o <= (st_q == ST_IDLE) && !req_valid_i;
         rdata_valid_o <= 1'b0;
         done_o <= 1'b0;
         // take data at strobe end: the synced copy still shows the selected byte there
         if (st_q == ST_STROBE && tmr_done && cur_q.op == NVC_OP_READ) begin
            rd_hold_q <= dq_sync2_q; // [R1]
         end
         if (st_q == ST_HOLD && tmr_done && cur_q.op == NVC_OP_READ) begin
            rdata_o <= rd_hold_q;
            rdata_valid_o <= 1'b1;
         end
         if ((st_q == ST_HOLD && tmr_done && !seq_op) || (st_q == ST_NVWAIT && tmr_done) ||
             (st_q == ST_BUSY && tmr_done && sb_sync_q[1])) begin
            done_o <= 1'b1;
         end
      end
   end

   chk_we_seq_high: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R8]
      (seq_op && st_q != ST_IDLE) |-> pins_o.we_n)
      else $error("strobe low during sequence");
   chk_read_strobe: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R3]
      !pins_o.oe_n |-> pins_o.we_n && !pins_o.ce_n)
      else $error("read with strobe low");
   chk_write_nodrv_oe: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R2]
      !pins_o.we_n |-> pins_o.dq_oe && pins_o.oe_n && pins_o.store_busy_n_oe == 1'b0)
      else $error("write pins wrong");
   chk_deselect_idle: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R15]
      pins_o.ce_n |-> pins_o.we_n && !pins_o.dq_oe)
      else $error("deselected bus driven");
   chk_nv_quiet: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R13]
      st_q == ST_NVWAIT |-> ##1 (pins_o.ce_n && pins_o.we_n))
      else $error("pins active during transfer");
   chk_busy_hold: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R11]
      (st_q == ST_BUSY && !sb_sync_q[1]) |=> st_q == ST_BUSY)
      else $error("left inhibit while busy low");
   chk_hw_pulse: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R10]
      $rose(pins_o.store_busy_n_oe) |-> pins_o.store_busy_n_oe [*5])
      else $error("store pulse too short");
   chk_seq_last: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R6]
      (st_q == ST_STROBE && cur_q.op == NVC_OP_SW_STORE && step_q == 3'd5) |=> pins_o.addr == SEQ_STORE)
      else $error("store sequence last address wrong");

   cov_read: cover property (@(posedge core_clk_i) disable iff (rst_i) rdata_valid_o);
   cov_sw_store: cover property (@(posedge core_clk_i) disable iff (rst_i)
      st_q == ST_NVWAIT && cur_q.op == NVC_OP_SW_STORE);
   cov_sw_recall: cover property (@(posedge core_clk_i) disable iff (rst_i)
      st_q == ST_NVWAIT && cur_q.op == NVC_OP_SW_RECALL);
   cov_hw_store: cover property (@(posedge core_clk_i) disable iff (rst_i) st_q == ST_BUSY ##1 done_o);
endmodule // nvc_host

// [nvc_mem_model.sv]
module nvc_mem_model
   import nvc_pkg::*;
#(
   parameter int NV_CYC = 10
) (
   // timing reference
   input wire logic core_clk_i,
   // memory pins
   input wire nvc_pins_s pins_i,
   input wire logic [7:0] dq_bus_i,
   input wire logic store_busy_n_i,
   output logic [7:0] dq_o,
   output logic dq_oe_o,
   output logic busy_pull_o,
   // transfer counts
   output int store_cnt_o,
   output int recall_cnt_o
);
   logic [7:0] mem [8192];
   logic [7:0] shadow [8192];
   logic [12:0] seq_tab [5] = '{SEQ_A0, SEQ_A1, SEQ_A2, SEQ_A3, SEQ_A4};
   logic dirty = 0, wr_at_sel = 0, hw_seen = 0, hw_run = 0, is_store = 0;
   int nv_cnt = 0, seq = 0;
   // sram content known so the bench can predict reads
   initial begin
      for (int i = 0; i < 8192; i++) mem[i] = 8'(i * 7);
      shadow = '{default: 8'hC3};
      store_cnt_o = 0;
      recall_cnt_o = 0;
   end
   // sequence steps on select falling; nothing counts during a transfer
   always @(negedge pins_i.ce_n) begin
      wr_at_sel = !pins_i.we_n;
      if (nv_cnt == 0 && store_busy_n_i) begin
         if (!pins_i.we_n) seq = 0;
         else if (seq == 5 && (pins_i.addr == SEQ_STORE || pins_i.addr == SEQ_RECALL)) begin
            is_store = (pins_i.addr == SEQ_STORE);
            nv_cnt = NV_CYC;
            seq = 0;
         end
         else if (seq < 5 && pins_i.addr == seq_tab[seq]) seq = seq + 1;
         else seq = (pins_i.addr == SEQ_A0) ? 1 : 0;
      end
   end
   // writes, busy-line store and timed transfers
   always @(posedge core_clk_i) begin
      if (nv_cnt == 0 && !pins_i.ce_n && !pins_i.we_n && store_busy_n_i) begin
         mem[pins_i.addr] = dq_bus_i;
         dirty = 1;
      end
      if (!store_busy_n_i && nv_cnt == 0 && !hw_seen) begin
         hw_seen = 1;
         if (dirty) begin
            is_store = 1;
            hw_run <= 1; // busy line moves off the sampling instant
            nv_cnt = NV_CYC;
         end
      end
      if (store_busy_n_i) hw_seen = 0;
      if (nv_cnt == 1) begin
         if (is_store) begin
            shadow = mem;
            dirty = 0;
            store_cnt_o++;
         end
         else begin
            mem = shadow;
            recall_cnt_o++;
         end
         hw_run <= 0;
      end
      if (nv_cnt > 0) nv_cnt--;
   end
   // device holds the busy line low while a store started from the busy line runs
   assign busy_pull_o = hw_run;
   assign dq_oe_o = !pins_i.ce_n && !pins_i.oe_n && pins_i.we_n && store_busy_n_i && nv_cnt == 0 && !wr_at_sel;
   assign dq_o = mem[pins_i.addr];
endmodule // nvc_mem_model

// [tb_nvc_host.sv]
module tb_nvc_host
   import nvc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk_i = 0, rst_i = 1, req_valid_i = 0, flt = 0, req_ready, rdata_valid, done, m_oe, pull;
   nvc_req_s req_i = '0;
   nvc_pins_s pins;
   logic [7:0] rdata, m_dq, dq_i, got, d;
   logic [12:0] a;
   logic busy_line;
   int st_cnt, rc_cnt, s0;
   int n_mismatch = 0, samples_checked = 0;
   int wl_cnt = 0, ol_cnt = 0;
   logic [7:0] ref_mem [8192];
   logic [7:0] ref_sh [8192];
   // open-drain busy line; released data bus wobbles so stale values never match
   assign busy_line = !(pins.store_busy_n_oe || pull);
   assign dq_i = m_oe ? m_dq : (pins.dq_oe ? pins.dq_out : {8{flt}});
   always @(posedge core_clk_i) flt <= ~flt;
   // strobe and output-enable cycles seen on the pins
   always @(posedge core_clk_i) begin
      if (!rst_i && !pins.we_n) wl_cnt++;
      if (!rst_i && !pins.oe_n) ol_cnt++;
   end
   initial forever #25 core_clk_i = ~core_clk_i;
   nvc_host #(.STORE_CYC(20), .RECALL_CYC(20)) uut (.core_clk_i(core_clk_i), .rst_i(rst_i), .req_i(req_i),
      .req_valid_i(req_valid_i), .req_ready_o(req_ready), .rdata_o(rdata), .rdata_valid_o(rdata_valid),
      .done_o(done), .pins_o(pins), .dq_i(dq_i), .store_busy_n_i(busy_line));
   nvc_mem_model #(.NV_CYC(10)) mem_i (.core_clk_i(core_clk_i), .pins_i(pins), .dq_bus_i(dq_i),
      .store_busy_n_i(busy_line), .dq_o(m_dq), .dq_oe_o(m_oe), .busy_pull_o(pull), .store_cnt_o(st_cnt),
      .recall_cnt_o(rc_cnt));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // one command, then wait for done under a bound
   task automatic run_op(input nvc_op_e op, input logic [12:0] ad, input logic [7:0] dd);
      int k;
      @(posedge core_clk_i);
      #2;
      req_i = '{op, ad, dd};
      req_valid_i = 1;
      @(posedge core_clk_i);
      #2;
      req_valid_i = 0;
      k = 0;
      while (done !== 1'b1 && k < 2000) begin
         if (rdata_valid === 1'b1) got = rdata;
         @(posedge core_clk_i);
         #2;
         k++;
      end
      if (rdata_valid === 1'b1) got = rdata;
      if (k == 2000) n_mismatch++;
   endtask
   initial begin
      repeat (20000) @(posedge core_clk_i);
      n_mismatch++;
      complete_run();
   end
   initial begin
      void'($urandom(83314));
      for (int i = 0; i < 8192; i++) ref_mem[i] = 8'(i * 7);
      ref_sh = '{default: 8'hC3};
      repeat (2) @(posedge core_clk_i);
      #2;
      rst_i = 0;
      check(pins.ce_n, 1'b1);
      check(pins.dq_oe, 1'b0);
      // random writes with read-back, plus reads elsewhere
      repeat (12) begin
         a = 13'($urandom);
         d = 8'($urandom);
         run_op(NVC_OP_WRITE, a, d);
         ref_mem[a] = d;
         run_op(NVC_OP_READ, a, 8'h00);
         check(got, d);
         a = 13'($urandom);
         run_op(NVC_OP_READ, a, 8'h00);
         check(got, ref_mem[a]);
      end
      $display("test read write done");
      // software store, then busy-line store with nothing new written
      s0 = st_cnt;
      run_op(NVC_OP_SW_STORE, 13'h0000, 8'h00);
      check(st_cnt, s0 + 1);
      ref_sh = ref_mem;
      run_op(NVC_OP_HW_STORE, 13'h0000, 8'h00);
      check(st_cnt, s0 + 1);
      run_op(NVC_OP_READ, 13'h0F0F, 8'h00);
      check(got, ref_mem[13'h0F0F]);
      $display("test store done");
      // top address written, busy-line store, overwrite, recall restores
      run_op(NVC_OP_WRITE, 13'h1FFF, 8'hA5);
      run_op(NVC_OP_HW_STORE, 13'h0000, 8'h00);
      check(st_cnt, s0 + 2);
      run_op(NVC_OP_WRITE, 13'h1FFF, 8'h3C);
      run_op(NVC_OP_SW_RECALL, 13'h0000, 8'h00);
      check(rc_cnt, 1);
      run_op(NVC_OP_READ, 13'h1FFF, 8'h00);
      check(got, 8'hA5);
      a = 13'($urandom);
      run_op(NVC_OP_READ, a, 8'h00);
      check(got, (a == 13'h1FFF) ? 8'hA5 : ref_sh[a]);
      @(posedge core_clk_i);
      #2;
      check(req_ready, 1'b1);
      check(pins.ce_n, 1'b1);
      check(wl_cnt, 14 * CYC_PHASE);
      check(ol_cnt, 27 * CYC_PHASE);
      $display("test recall done");
      complete_run();
   end
endmodule // tb_nvc_host
